// *** verilog/tmr_core.v ***
// 16-bit timer core: counting modes, registers, compare pins, interrupt
//
// Behaviour
// - Mode and compare fields jointly set behaviour
// - Only waveform mode changes the counting sequence
// - PWM modes: compare field picks output polarity
// - Non-PWM: match sets, clears or toggles pin
// - Mode zero counts up, never clears
// - Free-running wraps maximum straight to zero
// - Overflow flag set on wrap from maximum or at PWM top
// - Counter only sets overflow, never clears it
// - Taking overflow interrupt clears the flag
// - Count writable any time in free-running mode
// - Compare matches raise interrupts in free-running mode
// - Clear-on-match: zero on A (4) or capture (12)
// - Compare field zero: no pin action
// - New compare field acts at next match, top or force
// - Force strobe applies action now, non-PWM
// - Top below count: run to maximum, wrap
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`include "tmr_defs.vh"
`default_nettype none

// One 16-bit counter with two compare channels. The waveform mode
// alone picks the counting sequence; each compare mode only picks
// what its pin does at an event. Everything is reached over a
// single-cycle register port that never makes the master wait.
module tmr_core (
    input  wire        i_clk,
    input  wire        i_rst,
    // Register port: strobes are one-cycle pulses
    input  wire [7:0]  i_addr,
    input  wire [15:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    // Overflow interrupt taken, clears that flag
    input  wire        i_irq_ack,
    // Every output below comes straight from a flop
    output reg  [15:0] o_rdata,
    output reg         o_irq,
    output wire [1:0]  o_cmp_pin
);

    // Software-visible state
    // All clear at reset: stopped clock, mode zero, no actions
    reg  [15:0] ctrl;          // Mode, compare modes, clock select
    reg  [15:0] count_value;   // Running count
    reg  [15:0] cmp_val [0:1]; // Compare values A and B
    reg  [15:0] capture_value; // Capture / alternative top value
    reg  [15:0] status;        // Sticky event flags
    reg  [15:0] mask;          // Interrupt enables

    // Decoded fields
    wire [3:0]  waveform_mode_field;
    wire [1:0]  com_field [0:1];
    wire [2:0]  clk_sel;

    // Timing and event nets
    // Events are one-cycle pulses on the system clock
    wire        tick;          // Prescaled timer clock enable
    wire        pwm;           // A modulation mode is selected
    wire [15:0] pwm_top;       // Top value in modulation modes
    wire        at_top;        // Modulation count sits on top
    wire        ctc_hit;       // Clear-on-match condition
    wire        count_wr;      // Software writes the count
    wire        ovf_evt;       // Count wraps to zero this cycle
    wire [1:0]  match_evt;     // Compare match, per channel
    wire [1:0]  force_evt;     // Force strobe, per channel
    reg  [15:0] next_count;    // Count after this edge
    reg  [15:0] next_status;   // Flags after this edge
    reg  [15:0] rd_mux;        // Read data before registering

    // True for the single-slope modulation modes only
    // Dual-slope codes are not built and step like mode zero
    function is_pwm;
        input [3:0] wm;
        begin
            is_pwm = (wm == `TMR_WM_FPWM8)    ||
                     (wm == `TMR_WM_FPWM9)    ||
                     (wm == `TMR_WM_FPWM10)   ||
                     (wm == `TMR_WM_FPWM_CAP) ||
                     (wm == `TMR_WM_FPWM_A);
        end
    endfunction

    // Address decode, shared by the write and read paths
    // Exact compare: no aliasing of the word addresses
    function hit;
        input [7:0] addr;
        input [7:0] reg_addr;
        begin
            hit = (addr == reg_addr);
        end
    endfunction

    // Field extraction
    assign waveform_mode_field = ctrl[`TMR_CTRL_WM];
    assign com_field[0]        = ctrl[`TMR_CTRL_COMA];
    assign com_field[1]        = ctrl[`TMR_CTRL_COMB];
    assign clk_sel             = ctrl[`TMR_CTRL_CS];

    // Prescaled enable for every count step
    // Shared by both channels, so they step in lockstep
    tmr_prescale u_prescale (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_sel  (clk_sel),
        .o_tick (tick)
    );

    // Counting follows the waveform field alone; the compare
    // fields never reach this logic
    assign pwm = is_pwm(waveform_mode_field);

    // Modulation top: fixed widths or a software register
    // Mode 15 uses compare A directly, without a buffer
    assign pwm_top =
        (waveform_mode_field == `TMR_WM_FPWM8)    ? `TMR_TOP8  :
        (waveform_mode_field == `TMR_WM_FPWM9)    ? `TMR_TOP9  :
        (waveform_mode_field == `TMR_WM_FPWM10)   ? `TMR_TOP10 :
        (waveform_mode_field == `TMR_WM_FPWM_CAP) ? capture_value :
                                                    cmp_val[0];

    // Outside modulation modes there is no top event at all
    assign at_top = pwm && (count_value == pwm_top);

    // Equality only; a top written below the count is passed by
    // and the counter runs through maximum first
    assign ctc_hit =
        // Only modes 4 and 12 may clear, so mode zero never does
        ((waveform_mode_field == `TMR_WM_CTC_A) &&
         (count_value == cmp_val[0])) ||
        ((waveform_mode_field == `TMR_WM_CTC_CAP) &&
         (count_value == capture_value));

    // A count write takes priority over the step in its cycle
    assign count_wr = i_wr && hit(i_addr, `TMR_REG_COUNT);

    // Wrap from maximum or restart from top, on a timer step.
    // A software write of the count wins that cycle.
    // In clear-on-match a hit wins over the wrap at maximum.
    assign ovf_evt = tick && !count_wr &&
                     (((count_value == `TMR_MAX) && !ctc_hit) ||
                      at_top);

    // Next count value; holds between ticks, so a stopped clock
    // select freezes the count but leaves it writable
    always @* begin
        // Default: hold
        next_count = count_value;
        if (count_wr) begin
            // Accepted in any state, no guard
            next_count = i_wdata;
        end else if (tick) begin
            // Clear on a match or at the modulation top
            if (ctc_hit || at_top) begin
                // Clear on match only outside mode zero
                next_count = `TMR_BOTTOM;
            end else begin
                // Plain increment wraps maximum to zero
                next_count = count_value + 16'h0001;
            end
        end
    end

    // Count register
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            // Bottom, with the clock stopped by the control reset
            count_value <= `TMR_BOTTOM;
        end else begin
            // Every edge; the hold lives in the next value
            count_value <= next_count;
        end
    end

    // Per-channel match, force decode and output unit
    // Channel 0 is compare A, channel 1 compare B
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_cmp
            // Matches only on a step; a count write blocks them
            assign match_evt[ch] = tick && !count_wr &&
                                   (count_value == cmp_val[ch]);
            // Force strobe is write-only and self-clearing
            assign force_evt[ch] = i_wr &&
                                   hit(i_addr, `TMR_REG_FORCE) &&
                                   i_wdata[ch];

            // Top event is gated like a match: only on a step
            tmr_cmp_unit u_cmp (
                .i_clk   (i_clk),
                .i_rst   (i_rst),
                .i_match (match_evt[ch]),
                .i_top   (tick && !count_wr && at_top),
                .i_force (force_evt[ch]),
                .i_pwm   (pwm),
                .i_com   (com_field[ch]),
                .o_pin   (o_cmp_pin[ch])
            );
        end
    endgenerate

    // Configuration registers
    // Unused control and mask bits are dropped at the write
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl          <= `TMR_CTRL_RST;
            cmp_val[0]    <= `TMR_BOTTOM;
            cmp_val[1]    <= `TMR_BOTTOM;
            capture_value <= `TMR_BOTTOM;
            mask          <= 16'h0000;
        end else if (i_wr) begin
            // Compare field takes effect at its next event
            if (hit(i_addr, `TMR_REG_CTRL))
                ctrl <= i_wdata & `TMR_CTRL_USED;
            // Compare A doubles as the top in modes 4 and 15
            if (hit(i_addr, `TMR_REG_CMPA))
                cmp_val[0] <= i_wdata;
            if (hit(i_addr, `TMR_REG_CMPB))
                cmp_val[1] <= i_wdata;
            // No double buffering of the top value
            if (hit(i_addr, `TMR_REG_CAPT))
                capture_value <= i_wdata;
            // Mask only gates the interrupt, never the flags
            if (hit(i_addr, `TMR_REG_MASK))
                mask <= i_wdata & `TMR_ST_USED;
        end
    end

    // Sticky flags: clears first, then sets, so an event in the
    // clearing cycle is kept
    always @* begin
        next_status = status;
        // Write one to clear; zeros leave a flag alone
        if (i_wr && hit(i_addr, `TMR_REG_STATUS))
            next_status = next_status & ~i_wdata;
        // Interrupt taken clears overflow in hardware
        if (i_irq_ack)
            next_status[`TMR_ST_OVF] = 1'b0;
        // Counter side only ever sets
        if (ovf_evt)
            next_status[`TMR_ST_OVF] = 1'b1;
        // Match flags raise interrupts in every mode
        if (match_evt[0])
            next_status[`TMR_ST_MATCHA] = 1'b1;
        if (match_evt[1])
            next_status[`TMR_ST_MATCHB] = 1'b1;
        // Unused bits always read back as zero
        next_status = next_status & `TMR_ST_USED;
    end

    // Status register and level interrupt
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            status <= 16'h0000;
            o_irq  <= 1'b0;
        end else begin
            status <= next_status;
            // Taken from the next flags, so the level rises and
            // falls at the same edge as the flags themselves
            o_irq  <= |(next_status & mask);
        end
    end

    // Read selection; unmapped and write-only read as zero
    always @* begin
        // Default covers the force strobe and unmapped places
        rd_mux = 16'h0000;
        if (hit(i_addr, `TMR_REG_CTRL))
            rd_mux = ctrl;
        // Count as it stands before this edge's step
        if (hit(i_addr, `TMR_REG_COUNT))
            rd_mux = count_value;
        if (hit(i_addr, `TMR_REG_CMPA))
            rd_mux = cmp_val[0];
        if (hit(i_addr, `TMR_REG_CMPB))
            rd_mux = cmp_val[1];
        if (hit(i_addr, `TMR_REG_CAPT))
            rd_mux = capture_value;
        if (hit(i_addr, `TMR_REG_STATUS))
            rd_mux = status;
        if (hit(i_addr, `TMR_REG_MASK))
            rd_mux = mask;
        // Pins read back as driven, so software can poll them
        if (hit(i_addr, `TMR_REG_PINS))
            rd_mux = {14'h0, o_cmp_pin};
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            // Registered: data follows the strobe by one cycle
            o_rdata <= rd_mux;
        end else begin
            // Zero between reads keeps the bus quiet
            o_rdata <= 16'h0000;
        end
    end

endmodule
`default_nettype wire

// *** verilog/tmr_defs.vh ***
// Constants for the 16-bit timer: register map, fields, modes, timing
`ifndef TMR_DEFS_VH
`define TMR_DEFS_VH

// Register port widths
`define TMR_ADDR_W      8
`define TMR_DATA_W      16

// Register byte addresses (one word each)
`define TMR_REG_CTRL    8'h00
`define TMR_REG_FORCE   8'h04
`define TMR_REG_COUNT   8'h08
`define TMR_REG_CMPA    8'h0c
`define TMR_REG_CMPB    8'h10
`define TMR_REG_CAPT    8'h14
`define TMR_REG_STATUS  8'h18
`define TMR_REG_MASK    8'h1c
`define TMR_REG_PINS    8'h20

// Control register fields
`define TMR_CTRL_WM     3:0
`define TMR_CTRL_COMA   5:4
`define TMR_CTRL_COMB   7:6
`define TMR_CTRL_CS     10:8
`define TMR_CTRL_USED   16'h07ff
`define TMR_CTRL_RST    16'h0000

// Status and mask bit positions
`define TMR_ST_OVF      0
`define TMR_ST_MATCHA   1
`define TMR_ST_MATCHB   2
`define TMR_ST_USED     16'h0007

// Waveform mode field encodings
`define TMR_WM_NORMAL   4'h0
`define TMR_WM_CTC_A    4'h4
`define TMR_WM_FPWM8    4'h5
`define TMR_WM_FPWM9    4'h6
`define TMR_WM_FPWM10   4'h7
`define TMR_WM_CTC_CAP  4'hc
`define TMR_WM_FPWM_CAP 4'he
`define TMR_WM_FPWM_A   4'hf

// Fixed top values and the counter maximum
`define TMR_TOP8        16'h00ff
`define TMR_TOP9        16'h01ff
`define TMR_TOP10       16'h03ff
`define TMR_MAX         16'hffff
`define TMR_BOTTOM      16'h0000

// Compare output mode field encodings
`define TMR_COM_NONE    2'h0
`define TMR_COM_TOGGLE  2'h1
`define TMR_COM_CLEAR   2'h2
`define TMR_COM_SET     2'h3

// Clock select codes and prescaler masks (divide by mask + 1)
`define TMR_CS_STOP     3'h0
`define TMR_CS_DIV1     3'h1
`define TMR_CS_DIV8     3'h2
`define TMR_CS_DIV64    3'h3
`define TMR_CS_DIV256   3'h4
`define TMR_CS_DIV1024  3'h5
`define TMR_PS_M1       10'h000
`define TMR_PS_M8       10'h007
`define TMR_PS_M64      10'h03f
`define TMR_PS_M256     10'h0ff
`define TMR_PS_M1024    10'h3ff

`endif

// *** verilog/tmr_prescale.v ***
// Prescaler producing the one-cycle timer clock enable
`include "tmr_defs.vh"
`default_nettype none

module tmr_prescale (
    input  wire       i_clk,
    input  wire       i_rst,
    input  wire [2:0] i_sel,
    output reg        o_tick
);

    reg  [9:0] div;     // Free-running divide counter
    wire [9:0] mask;    // Low bits that must all be set

    // Clock select to prescaler mask
    function [9:0] ps_mask;
        input [2:0] sel;
        begin
            case (sel)
                `TMR_CS_DIV8:    ps_mask = `TMR_PS_M8;
                `TMR_CS_DIV64:   ps_mask = `TMR_PS_M64;
                `TMR_CS_DIV256:  ps_mask = `TMR_PS_M256;
                `TMR_CS_DIV1024: ps_mask = `TMR_PS_M1024;
                default:         ps_mask = `TMR_PS_M1;
            endcase
        end
    endfunction

    assign mask = ps_mask(i_sel);

    // Shared divider; changing the select may shorten one period
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            div    <= 10'h000;
            o_tick <= 1'b0;
        end else begin
            div    <= div + 10'h001;
            // Stopped or reserved codes give no tick
            o_tick <= (i_sel != `TMR_CS_STOP) &&
                      (i_sel <= `TMR_CS_DIV1024) &&
                      ((div & mask) == mask);
        end
    end

endmodule
`default_nettype wire

// *** verilog/tmr_cmp_unit.v ***
// Compare output unit: drives one compare output pin
`include "tmr_defs.vh"
`default_nettype none

module tmr_cmp_unit (
    input  wire       i_clk,
    input  wire       i_rst,
    input  wire       i_match,
    input  wire       i_top,
    input  wire       i_force,
    input  wire       i_pwm,
    input  wire [1:0] i_com,
    output reg        o_pin
);

    // Mode field is read only at an event, so a new setting
    // first acts at the next match, top or force, never on the spot
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pin <= 1'b0;
        end else if (i_pwm) begin
            // Modulation: polarity chosen by the field
            if (i_com == `TMR_COM_CLEAR) begin
                // Non-inverted: set on match, cleared at top
                if (i_top)
                    o_pin <= 1'b0;
                else if (i_match)
                    o_pin <= 1'b1;
            end else if (i_com == `TMR_COM_SET) begin
                // Inverted: cleared on match, set at top
                if (i_top)
                    o_pin <= 1'b1;
                else if (i_match)
                    o_pin <= 1'b0;
            end
            // Force strobe has no effect here
        end else if (i_match || i_force) begin
            case (i_com)
                `TMR_COM_TOGGLE: o_pin <= ~o_pin;
                `TMR_COM_CLEAR:  o_pin <= 1'b0;
                `TMR_COM_SET:    o_pin <= 1'b1;
                default:         o_pin <= o_pin;
            endcase
        end
    end

endmodule
`default_nettype wire

// *** testbench/tmr_core_monitor.sv ***
// Port-level checker for the timer core, bound into it
`include "tmr_defs.vh"
`default_nettype none
module tmr_core_monitor (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic [7:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic        i_irq_ack,
    input wire logic [15:0] o_rdata,
    input wire logic        o_irq,
    input wire logic [1:0]  o_cmp_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] sh_ctrl;   // Control word as last written
    logic [2:0]  sh_mask;   // Interrupt mask as last written
    wire  [3:0]  wm    = sh_ctrl[3:0];
    wire  [1:0]  com_a = sh_ctrl[5:4];
    // Fast PWM codes; the rest are non-PWM, where force acts
    wire         pwm   = (wm == 4'h5) || (wm == 4'h6) || (wm == 4'h7) ||
                         (wm >= 4'he);
    // Codes 6 and 7 stop the clock as well
    wire         stop  = (sh_ctrl[10:8] == 3'h0) || (sh_ctrl[10:8] >= 3'h6);
    wire         frc_a = i_wr && (i_addr == `TMR_REG_FORCE) && i_wdata[0];
    wire         fa    = frc_a && !pwm;

    // Shadow of the bus writes, so no internal probes are needed
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sh_ctrl <= 11'h000;
            sh_mask <= 3'h0;
        end else if (i_wr && i_addr == `TMR_REG_CTRL) begin
            sh_ctrl <= i_wdata[10:0];
        end else if (i_wr && i_addr == `TMR_REG_MASK) begin
            sh_mask <= i_wdata[2:0];
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // Three stopped samples: a tick already in flight has passed
    sequence quiet_s;
        stop [*3];
    endsequence

    force_set_a: assert property (quiet_s ##0 (fa && com_a == 2'h3)
        |=> o_cmp_pin[0]) else $error("force did not set pin A");
    force_clear_a: assert property (quiet_s ##0 (fa && com_a == 2'h2)
        |=> !o_cmp_pin[0]) else $error("force did not clear pin A");
    force_toggle_a: assert property (quiet_s ##0 (fa && com_a == 2'h1)
        |=> o_cmp_pin[0] != $past(o_cmp_pin[0]))
        else $error("force did not toggle pin A");
    force_none_a: assert property (quiet_s ##0 (fa && com_a == 2'h0)
        |=> $stable(o_cmp_pin[0])) else $error("pin A moved with action off");
    force_pwm_a: assert property (quiet_s ##0 (frc_a && pwm)
        |=> $stable(o_cmp_pin[0])) else $error("force acted in a PWM mode");
    stop_hold_a: assert property (quiet_s ##0
        !(i_wr && i_addr == `TMR_REG_FORCE) |=> $stable(o_cmp_pin))
        else $error("pins moved with the clock stopped");
    ack_clear_a: assert property (quiet_s ##0
        (i_irq_ack && sh_mask == 3'h1) |-> ##[1:2] !o_irq)
        else $error("interrupt stayed up after acknowledge");
    mask_off_a: assert property (
        (i_wr && i_addr == `TMR_REG_MASK && i_wdata[2:0] == 3'h0)
        |-> ##[1:2] !o_irq) else $error("masked interrupt still raised");
    irq_mask_a: assert property ((sh_mask == 3'h0) [*3] |-> !o_irq)
        else $error("interrupt raised with all sources masked");
    pins_read_a: assert property (i_rd && i_addr == `TMR_REG_PINS
        |=> o_rdata == {14'h0, $past(o_cmp_pin)})
        else $error("pin readback differs from the pins");
endmodule

bind tmr_core tmr_core_monitor u_mon (.i_clk(i_clk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .i_irq_ack(i_irq_ack), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_cmp_pin(o_cmp_pin));
`default_nettype wire

// *** testbench/tmr_core_tb_top.sv ***
// Self-checking bench for the timer core
`include "tmr_defs.vh"
`default_nettype none
module tmr_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk = 1'b0;     // 20 MHz system clock
    logic        i_rst = 1'b1;     // Asynchronous reset
    logic [7:0]  i_addr = 8'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        i_irq_ack = 1'b0;
    logic [15:0] o_rdata;
    logic        o_irq;
    logic [1:0]  o_cmp_pin;
    logic        rd_d = 1'b0;      // A read was taken at the last edge
    logic [23:0] exp_q[$];         // Address and expected word per read
    logic [23:0] ent;
    logic [15:0] x;
    int          failures = 0;
    int          cmp_count = 0;
    int          i;
    // Registers read right after reset, plus one unmapped place
    logic [7:0]  regs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h18,
                              8'h1c, 8'h24};
    // Force table: control word and expected pin A afterwards
    logic [15:0] ctl [6] = '{16'h0030, 16'h0020, 16'h0010, 16'h0000,
                             16'h0010, 16'h0035};
    logic [5:0]  pe = 6'h0d;

    tmr_core DUT (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_irq_ack(i_irq_ack),
        .o_rdata(o_rdata), .o_irq(o_irq), .o_cmp_pin(o_cmp_pin));

    // Clock generator
    always #25 i_clk = ~i_clk;

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_wr <= 1'b1;
        i_rd <= 1'b0;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
    endtask
    // Read strobe; the expected word goes to the queue for the watcher
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        i_addr <= a;
        exp_q.push_back({a, e});
        @(posedge i_clk);
    endtask
    task automatic idle(input int n);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        repeat (n) @(posedge i_clk);
    endtask
    task automatic chk16(input logic [7:0] a, input logic [15:0] e,
                         input logic [15:0] s);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("mismatch reg %h expected %h seen %h", a, e, s);
        end
    endtask
    // Sampled mid-cycle so the edge's updates have landed
    task automatic chk_irq(input logic e);
        @(negedge i_clk);
        cmp_count++;
        if (o_irq !== e) begin
            failures++;
            $display("mismatch o_irq expected %b seen %b", e, o_irq);
        end
        @(posedge i_clk);
    endtask
    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watcher: read data stands only in the cycle after the strobe
    always @(posedge i_clk) rd_d <= i_rd;
    always @(negedge i_clk) begin
        if (rd_d) begin
            ent = exp_q.pop_front();
            chk16(ent[23:16], ent[15:0], o_rdata);
        end
    end

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge i_clk);
        failures++;
        $display("watchdog expired");
        stop_test();
    end

    initial begin
        x = 16'($urandom(32'h56b0));
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        foreach (regs[k]) rd(regs[k], 16'h0000);
        $display("reset value test done");
        // Free-running wrap; compare B kept out of reach
        wr(`TMR_REG_CMPB, 16'hfff0);
        wr(`TMR_REG_CMPA, `TMR_MAX);
        wr(`TMR_REG_MASK, 16'h0001);
        wr(`TMR_REG_CTRL, 16'h0100);
        idle(4);
        wr(`TMR_REG_COUNT, 16'hfffe);
        rd(`TMR_REG_COUNT, 16'hfffe);
        rd(`TMR_REG_STATUS, 16'h0000);
        rd(`TMR_REG_STATUS, 16'h0003);
        rd(`TMR_REG_COUNT, 16'h0001);
        rd(`TMR_REG_PINS, 16'h0000);
        idle(1);
        chk_irq(1'b1);
        idle(6);
        rd(`TMR_REG_STATUS, 16'h0003);
        // Random reloads with a compare action set: stepping unchanged
        wr(`TMR_REG_CTRL, 16'h0110);
        idle(4);
        for (i = 0; i < 4; i++) begin
            x = 16'($urandom) & 16'h7fff;
            wr(`TMR_REG_COUNT, x);
            rd(`TMR_REG_COUNT, x);
            rd(`TMR_REG_COUNT, x + 16'h0001);
        end
        wr(`TMR_REG_CTRL, 16'h0000);
        idle(4);
        i_irq_ack <= 1'b1;
        @(posedge i_clk);
        i_irq_ack <= 1'b0;
        idle(2);
        chk_irq(1'b0);
        rd(`TMR_REG_STATUS, 16'h0002);
        wr(`TMR_REG_STATUS, 16'h0002);
        rd(`TMR_REG_STATUS, 16'h0000);
        $display("normal mode test done");
        // Clear on compare A, pin set on match
        wr(`TMR_REG_CMPA, 16'h0002);
        wr(`TMR_REG_CTRL, 16'h0134);
        idle(4);
        wr(`TMR_REG_COUNT, 16'h0000);
        for (i = 0; i < 7; i++) rd(`TMR_REG_COUNT, 16'(i % 3));
        rd(`TMR_REG_PINS, 16'h0001);
        wr(`TMR_REG_CTRL, 16'h0024);
        idle(3);
        rd(`TMR_REG_PINS, 16'h0001);
        wr(`TMR_REG_CTRL, 16'h0124);
        idle(8);
        rd(`TMR_REG_PINS, 16'h0000);
        // Clear on the capture register
        wr(`TMR_REG_CAPT, 16'h0003);
        wr(`TMR_REG_CTRL, 16'h010c);
        idle(4);
        wr(`TMR_REG_COUNT, 16'h0000);
        for (i = 0; i < 6; i++) rd(`TMR_REG_COUNT, 16'(i % 4));
        // Top already passed: run to the maximum and wrap, before the match on A
        wr(`TMR_REG_CTRL, 16'h0104);
        idle(4);
        wr(`TMR_REG_COUNT, 16'hfff0);
        wr(`TMR_REG_STATUS, 16'h0007);
        idle(15);
        rd(`TMR_REG_STATUS, 16'h0005);
        $display("clear on match test done");
        // Force strobe under every compare action, then in a PWM mode
        wr(`TMR_REG_CTRL, 16'h0000);
        for (i = 0; i < 6; i++) begin
            wr(`TMR_REG_CTRL, ctl[i]);
            idle(3);
            wr(`TMR_REG_FORCE, 16'h0001);
            rd(`TMR_REG_PINS, {15'h0, pe[i]});
        end
        // Compare B under set, then clear, with the clock stopped
        wr(`TMR_REG_CTRL, 16'h00c0);
        wr(`TMR_REG_FORCE, 16'h0002);
        rd(`TMR_REG_PINS, 16'h0002);
        wr(`TMR_REG_CTRL, 16'h0080);
        wr(`TMR_REG_FORCE, 16'h0002);
        rd(`TMR_REG_PINS, 16'h0000);
        $display("force test done");
        // Fast PWM, non-inverted then inverted: match sets, then clears
        wr(`TMR_REG_CMPA, 16'h0010);
        for (i = 0; i < 2; i++) begin
            wr(`TMR_REG_CTRL, 16'h0125 | (16'(i) << 4));
            idle(4);
            wr(`TMR_REG_COUNT, 16'h000e);
            idle(4);
            rd(`TMR_REG_PINS, {15'h0, i == 0});
        end
        $display("pwm polarity test done");
        // Divide by 8: any 16 edges hold exactly two ticks
        wr(`TMR_REG_CTRL, 16'h0200);
        idle(2);
        wr(`TMR_REG_COUNT, 16'h0000);
        idle(16);
        rd(`TMR_REG_COUNT, 16'h0002);
        $display("prescaler test done");
        wr(`TMR_REG_MASK, 16'h0000);
        idle(3);
        chk_irq(1'b0);
        $display("interrupt mask test done");
        idle(2);
        stop_test();
    end
endmodule
`default_nettype wire
